// ===== src/ilc_ctrl.sv
// Functional notes
// - Six sources: two active-low pins, three timer overflows, one serial request.
// - Vectors follow the classic map: 0003h plus 8 per polling rank.
// - Each source has its own enable bit; cleared bit blocks it.
// - Enable bit 7 is the master enable; cleared blocks every source.
// - Enable bits: timer2 5, serial 4, timer1 3, ext1 2, timer0 1, ext0 0.
// - Enable register resets to zero; bit 6 is not stored.
// - High bit and low bit form a two-bit level, 3 highest.
// - Running routine is pre-empted only by a strictly higher level.
// - A level 3 routine is never pre-empted.
// - Among simultaneous requests the highest level is served first.
// - Equal levels are resolved by a fixed polling order.
// - Low level bits: timer2 5, serial 4, timer1 3, ext1 2, timer0 1, ext0 0.
// - Reserved bits read as zero; software must not write ones there.
// - Enable and low level registers accept single-bit set and clear.
// - High level register at B7h with the same bit layout.
// - Any enabled, active request clears the idle bit by hardware.
`timescale 1ns/1ps

module ilc_ctrl (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Request sources
	input  wire logic        ext_request_0_n,
	input  wire logic        ext_request_1_n,
	input  wire logic        timer0_ovf,
	input  wire logic        timer1_ovf,
	input  wire logic        timer2_ovf,
	input  wire logic        serial_req,
	// Special-function byte access
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// Special-function bit access
	input  wire logic        bit_wr,
	input  wire logic [7:0]  bit_addr,
	input  wire logic        bit_val,
	// Core vectoring
	input  wire logic        irq_ack,
	input  wire logic        irq_reti,
	output logic             irq_req,
	output logic      [15:0] irq_vector,
	output logic      [1:0]  irq_level,
	output logic      [5:0]  src_ack,
	// Power mode
	output logic             idle_mode
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ilc_pkg::ilc_state_t st;
		logic [7:0]          mask;
		logic [5:0]          lvl_lo;
		logic [5:0]          lvl_hi;
		logic                idle;
		logic [3:0]          svc;
		logic                req;
		logic [2:0]          sel;
		logic [1:0]          lvl;
		logic [15:0]         vec;
		logic [5:0]          sack;
		logic [7:0]          rdata;
	} ilc_regs_t;

	localparam ilc_regs_t S_RESET = '{
		st:    ilc_pkg::ST_WAIT,
		mask:   ilc_pkg::MASK_RESET,
		lvl_lo: ilc_pkg::LVL_LO_RESET,
		lvl_hi: ilc_pkg::LVL_HI_RESET,
		idle:  1'b0,
		svc:   4'h0,
		req:   1'b0,
		sel:   3'h0,
		lvl:   2'h0,
		vec:   16'h0000,
		sack:  6'h00,
		rdata: 8'h00
	};

	ilc_regs_t s_q;
	ilc_regs_t s_d;

	// Highest level currently in service
	function automatic logic [1:0] ilc_top_level(input logic [3:0] svc);
		logic [1:0] l;
		l = 2'h0;
		for (int k = 0; k < ilc_pkg::NUM_LVL; k++) begin
			if (svc[k]) begin
				l = 2'(k);
			end
		end
		return l;
	endfunction : ilc_top_level

	// ----------------------------------------------------------------
	// Per-source qualification
	// ----------------------------------------------------------------
	logic [5:0] raw;
	logic [5:0] armed;
	logic [5:0] elig;
	logic [1:0] src_lvl [6];
	logic [1:0] cur_lvl;
	logic       busy;

	// Pins are active low; timer and serial flags are active high
	assign raw = {timer2_ovf, serial_req, timer1_ovf,
	              ~ext_request_1_n, timer0_ovf, ~ext_request_0_n};
	assign cur_lvl = ilc_top_level(s_q.svc);
	assign busy    = |s_q.svc;

	for (genvar i = 0; i < ilc_pkg::NUM_SRC; i++) begin : g_src
		assign armed[i]   = s_q.mask[ilc_pkg::GLOBAL_EN_BIT] & s_q.mask[i] & raw[i];
		assign src_lvl[i] = {s_q.lvl_hi[i], s_q.lvl_lo[i]};
		// Level 3 in service leaves nothing strictly above it
		assign elig[i]    = armed[i] & (!busy || src_lvl[i] > cur_lvl);
	end

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	logic       pick_ok;
	logic [2:0] pick_idx;
	logic [1:0] pick_lvl;

	// Scan in polling order; only a strictly higher level displaces,
	// so the earliest rank wins a tie
	always_comb begin
		pick_ok  = 1'b0;
		pick_idx = 3'h0;
		pick_lvl = 2'h0;
		for (int i = 0; i < ilc_pkg::NUM_SRC; i++) begin
			if (elig[i] && (!pick_ok || src_lvl[i] > pick_lvl)) begin
				pick_ok  = 1'b1;
				pick_idx = 3'(i);
				pick_lvl = src_lvl[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [3:0] svc_after_ret;

	always_comb begin
		s_d  = s_q;
		s_d.sack  = 6'h00;
		s_d.rdata = 8'h00;

		// Return releases only the innermost level
		svc_after_ret = s_q.svc;
		if (irq_reti && busy) begin
			svc_after_ret[cur_lvl] = 1'b0;
		end
		s_d.svc = svc_after_ret;

		case (s_q.st)
			ilc_pkg::ST_WAIT: begin
				if (pick_ok) begin
					s_d.st  = ilc_pkg::ST_OFFER;
					s_d.req = 1'b1;
					s_d.sel = pick_idx;
					s_d.lvl = pick_lvl;
					s_d.vec = ilc_pkg::VEC_BASE + {10'h000, pick_idx, 3'h0};
				end
			end
			ilc_pkg::ST_OFFER: begin
				if (irq_ack) begin
					// The core takes what was on the outputs this cycle
					s_d.svc[s_q.lvl] = 1'b1;
					s_d.sack[s_q.sel] = 1'b1;
					s_d.st  = ilc_pkg::ST_WAIT;
					s_d.req = 1'b0;
				end else if (pick_ok) begin
					// A better candidate may replace the offer before it is taken
					s_d.sel = pick_idx;
					s_d.lvl = pick_lvl;
					s_d.vec = ilc_pkg::VEC_BASE + {10'h000, pick_idx, 3'h0};
				end else begin
					s_d.st  = ilc_pkg::ST_WAIT;
					s_d.req = 1'b0;
				end
			end
			default: begin
				s_d.st  = ilc_pkg::ST_WAIT;
				s_d.req = 1'b0;
			end
		endcase

		// Byte writes; reserved bits are never stored
		if (sfr_wr) begin
			case (sfr_addr)
				ilc_pkg::MASK_ADDR:   s_d.mask   = sfr_wdata & ilc_pkg::MASK_WMASK;
				ilc_pkg::LVL_LO_ADDR: s_d.lvl_lo = sfr_wdata[5:0];
				ilc_pkg::LVL_HI_ADDR: s_d.lvl_hi = sfr_wdata[5:0];
				ilc_pkg::PWR_ADDR:    s_d.idle   = sfr_wdata[ilc_pkg::IDLE_BIT];
				default: begin
				end
			endcase
		end

		// Bit set and clear
		if (bit_wr) begin
			if (bit_addr[7:3] == ilc_pkg::MASK_ADDR[7:3] && bit_addr[2:0] != 3'(ilc_pkg::MASK_RSVD_BIT)) begin
				s_d.mask[bit_addr[2:0]] = bit_val;
			end
			if (bit_addr[7:3] == ilc_pkg::LVL_LO_ADDR[7:3] && bit_addr[2:0] < 3'(ilc_pkg::NUM_SRC)) begin
				s_d.lvl_lo[bit_addr[2:0]] = bit_val;
			end
		end

		// Wake wins over a software write in the same cycle, so no request is missed
		if (|armed) begin
			s_d.idle = 1'b0;
		end

		// Read data is valid the cycle after the strobe
		if (sfr_rd) begin
			case (sfr_addr)
				ilc_pkg::MASK_ADDR:   s_d.rdata = s_q.mask;
				ilc_pkg::LVL_LO_ADDR: s_d.rdata = {2'h0, s_q.lvl_lo};
				ilc_pkg::LVL_HI_ADDR: s_d.rdata = {2'h0, s_q.lvl_hi};
				ilc_pkg::PWR_ADDR:    s_d.rdata = {7'h00, s_q.idle};
				default:            s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_q <= S_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sfr_rdata  = s_q.rdata;
	assign irq_req    = s_q.req;
	assign irq_vector = s_q.vec;
	assign irq_level  = s_q.lvl;
	assign src_ack    = s_q.sack;
	assign idle_mode  = s_q.idle;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// Independent view of the arbiter: nothing eligible may outrank the pick
	logic [5:0] beats_pick;
	logic [5:0] early_tie;

	for (genvar i = 0; i < ilc_pkg::NUM_SRC; i++) begin : g_chk
		assign beats_pick[i] = elig[i] & (src_lvl[i] > pick_lvl);
		assign early_tie[i]  = elig[i] & (src_lvl[i] == pick_lvl) & (3'(i) < pick_idx);
	end

	sequence s_ret_taken;
		irq_reti && |s_q.svc && !(s_q.req && irq_ack);
	endsequence

	sequence s_ret_release;
		s_q.svc == ($past(s_q.svc) & ~(4'h1 << ilc_top_level($past(s_q.svc))));
	endsequence

	sequence s_mask0_set;
		bit_wr && bit_val && bit_addr == ilc_pkg::MASK_ADDR && !sfr_wr;
	endsequence

	a_reset_clear: assert property (
		!$past(resetn) |-> s_q.mask == ilc_pkg::MASK_RESET && !irq_req && s_q.svc == 4'h0)
		else $error("state not cleared after reset");

	a_master_gate: assert property (
		$rose(irq_req) |-> $past(s_q.mask[ilc_pkg::GLOBAL_EN_BIT]))
		else $error("request offered while master enable off");

	a_source_gate: assert property (
		$rose(irq_req) |-> (($past(s_q.mask[5:0] & raw) >> s_q.sel) & 6'h01) == 6'h01)
		else $error("request offered for a disabled or idle source");

	a_vector_map: assert property (
		irq_req |-> irq_vector == ilc_pkg::VEC_BASE + {10'h000, s_q.sel, 3'h0})
		else $error("vector does not match source");

	a_preempt_rule: assert property (
		$rose(irq_req) && $past(busy) |-> irq_level > $past(cur_lvl))
		else $error("pre-emption by equal or lower level");

	a_top_locked: assert property (
		s_q.svc[3] |=> !$rose(irq_req))
		else $error("level 3 routine pre-empted");

	a_level_first: assert property (
		pick_ok |-> beats_pick == 6'h00)
		else $error("offered level is not the best pending level");

	a_poll_order: assert property (
		pick_ok |-> early_tie == 6'h00)
		else $error("tie not resolved by polling order");

	a_idle_wake: assert property (
		|armed |=> !idle_mode)
		else $error("idle not cleared by enabled request");

	a_reti_release: assert property (
		s_ret_taken |=> s_ret_release)
		else $error("return did not release innermost level");

	a_ack_record: assert property (
		irq_req && irq_ack |=> s_q.svc[$past(irq_level)] && src_ack[$past(s_q.sel)] ##1 src_ack == 6'h00)
		else $error("acknowledge not recorded");

	a_bit_set: assert property (
		s_mask0_set |=> s_q.mask[0])
		else $error("bit set of enable register lost");

endmodule : ilc_ctrl

// ===== include/ilc_pkg.sv
package ilc_pkg;

	// ----------------------------------------------------------------
	// Register map (special-function space)
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_ADDR    = 8'hA8;
	localparam logic [7:0] LVL_LO_ADDR  = 8'hB8;
	localparam logic [7:0] LVL_HI_ADDR  = 8'hB7;
	localparam logic [7:0] PWR_ADDR     = 8'h87;

	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic [5:0] LVL_LO_RESET = 6'h00;
	localparam logic [5:0] LVL_HI_RESET = 6'h00;
	localparam logic [7:0] MASK_WMASK   = 8'hBF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GLOBAL_EN_BIT = 7;
	localparam int MASK_RSVD_BIT = 6;
	localparam int IDLE_BIT      = 0;
	localparam int NUM_SRC       = 6;
	localparam int NUM_LVL       = 4;

	// Source index equals its enable/level bit and its polling rank
	localparam int SRC_EXT0   = 0;
	localparam int SRC_TIMER0 = 1;
	localparam int SRC_EXT1   = 2;
	localparam int SRC_TIMER1 = 3;
	localparam int SRC_SERIAL = 4;
	localparam int SRC_TIMER2 = 5;

	// ----------------------------------------------------------------
	// Vector map: base plus eight bytes per polling rank
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam int          VEC_SHIFT = 3;

	// ----------------------------------------------------------------
	// Offer state machine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_WAIT  = 2'b01,
		ST_OFFER = 2'b10
	} ilc_state_t;

endpackage : ilc_pkg

// ===== bench/ilc_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Core side: takes offered vectors and issues returns on command
// ----------------------------------------------------------------
module ilc_core_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Offer from the controller
	input  wire logic        irq_req,
	input  wire logic [15:0] irq_vector,
	input  wire logic [1:0]  irq_level,
	// Bench control
	input  wire logic [3:0]  lag,
	input  wire logic        reti_go,
	// Answer and record
	output logic             irq_ack,
	output logic             irq_reti,
	output logic      [15:0] got_vector,
	output logic      [1:0]  got_level,
	output logic      [7:0]  n_taken
);
	logic [3:0] wait_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_ack    <= 1'b0;
			irq_reti   <= 1'b0;
			got_vector <= 16'h0000;
			got_level  <= 2'h0;
			n_taken    <= 8'h00;
			wait_q     <= 4'h0;
		end else begin
			irq_reti <= reti_go;
			// An ack is counted only where the offer is still up at the edge
			if (irq_ack && irq_req) begin
				got_vector <= irq_vector;
				got_level  <= irq_level;
				n_taken    <= n_taken + 8'h01;
			end
			if (irq_ack)
				irq_ack <= 1'b0;
			else if (irq_req && wait_q >= lag)
				irq_ack <= 1'b1;
			wait_q <= (irq_req && !irq_ack) ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule : ilc_core_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic        core_clk  = 1'b0;
	logic        resetn    = 1'b0;
	logic [5:0]  src_m     = 6'h00;
	logic [7:0]  sfr_addr  = 8'h00;
	logic        sfr_wr    = 1'b0;
	logic        sfr_rd    = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic        bit_wr    = 1'b0;
	logic [7:0]  bit_addr  = 8'h00;
	logic        bit_val   = 1'b0;
	logic [3:0]  lag       = 4'h0;
	logic        reti_go   = 1'b0;
	logic        irq_ack, irq_reti, irq_req, idle_mode;
	logic [15:0] irq_vector, got_vector;
	logic [1:0]  irq_level, got_level;
	logic [5:0]  src_ack;
	logic [7:0]  sfr_rdata, n_taken;
	int          bad_count  = 0;
	int          num_checks = 0;

	always #12.5 core_clk = ~core_clk;

	ilc_ctrl i_ilc_ctrl (.core_clk(core_clk), .resetn(resetn), .ext_request_0_n(~src_m[0]),
		.ext_request_1_n(~src_m[2]), .timer0_ovf(src_m[1]), .timer1_ovf(src_m[3]),
		.timer2_ovf(src_m[5]), .serial_req(src_m[4]), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr),
		.bit_addr(bit_addr), .bit_val(bit_val), .irq_ack(irq_ack), .irq_reti(irq_reti),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level), .src_ack(src_ack),
		.idle_mode(idle_mode));

	ilc_core_model i_ilc_core_model (.core_clk(core_clk), .resetn(resetn), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level), .lag(lag), .reti_go(reti_go),
		.irq_ack(irq_ack), .irq_reti(irq_reti), .got_vector(got_vector),
		.got_level(got_level), .n_taken(n_taken));

	// ----------------------------------------------------------------
	// Access and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge core_clk);
		sfr_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge core_clk);
		sfr_rd   <= 1'b0;
		#1;
		chk({8'h00, sfr_rdata}, {8'h00, exp});
	endtask : rd

	task automatic bw(input logic [7:0] a, input logic v);
		@(posedge core_clk);
		bit_addr <= a;
		bit_val  <= v;
		bit_wr   <= 1'b1;
		@(posedge core_clk);
		bit_wr   <= 1'b0;
	endtask : bw

	// Sources stay up until the core has taken one, as a real peripheral flag would
	task automatic take(input logic [5:0] m, input logic [15:0] v, input logic [1:0] l);
		logic [7:0] n0;
		n0 = n_taken;
		@(posedge core_clk);
		src_m <= m;
		for (int k = 0; k < 60 && n_taken === n0; k++) begin
			@(posedge core_clk);
			#1;
		end
		chk({8'h00, n_taken}, {8'h00, n0 + 8'h01});
		chk(got_vector, v);
		chk({14'h0, got_level}, {14'h0, l});
		chk({10'h0, src_ack}, 16'h0001 << ((v - 16'h0003) >> 3));
		chk({15'h0, irq_req}, 16'h0000);
		@(posedge core_clk);
		src_m <= 6'h00;
	endtask : take

	task automatic quiet(input logic [5:0] m);
		@(posedge core_clk);
		src_m <= m;
		repeat (6) @(posedge core_clk);
		#1;
		chk({15'h0, irq_req}, 16'h0000);
		@(posedge core_clk);
		src_m <= 6'h00;
	endtask : quiet

	task automatic reti;
		@(posedge core_clk);
		reti_go <= 1'b1;
		@(posedge core_clk);
		reti_go <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : reti

	task automatic tend(input string name);
		$display("test %s done", name);
	endtask : tend

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#500000;
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		rd(8'hA8, 8'h00);
		rd(8'hB8, 8'h00);
		rd(8'hB7, 8'h00);
		wr(8'h90, 8'hFF);
		rd(8'h90, 8'h00);
		wr(8'hA8, 8'hBF);
		rd(8'hA8, 8'hBF);
		wr(8'hB8, 8'h3F);
		rd(8'hB8, 8'h3F);
		wr(8'hB7, 8'h3F);
		rd(8'hB7, 8'h3F);
		wr(8'hA8, 8'h00);
		wr(8'hB8, 8'h00);
		wr(8'hB7, 8'h00);
		for (int i = 0; i < 8; i++)
			if (i != 6)
				bw(8'hA8 + 8'(i), 1'b1);
		bw(8'hAF, 1'b0);
		bw(8'hBD, 1'b1);
		rd(8'hA8, 8'h3F);
		rd(8'hB8, 8'h20);
		wr(8'hB8, 8'h00);
		tend("registers");
		for (int i = 0; i < 6; i++) begin
			wr(8'hA8, 8'h80 | (8'h01 << i));
			take(6'h3F, 16'h0003 + 16'(i * 8), 2'h0);
			reti();
		end
		wr(8'hA8, 8'h3F);
		quiet(6'h3F);
		wr(8'hA8, 8'hBF);
		tend("enables");
		for (int i = 0; i < 6; i++) begin
			take(6'h3F & (6'h3F << i), 16'h0003 + 16'(i * 8), 2'h0);
			reti();
		end
		lag <= 4'h3;
		for (int l = 0; l < 4; l++) begin
			wr(8'hB7, {2'b00, l[1], 5'h00});
			wr(8'hB8, {2'b00, l[0], 5'h00});
			take(6'h3F, (l == 0) ? 16'h0003 : 16'h002B, l[1:0]);
			reti();
		end
		lag <= 4'h0;
		tend("levels");
		wr(8'hB7, 8'h08);
		wr(8'hB8, 8'h0A);
		take(6'h02, 16'h000B, 2'h1);
		quiet(6'h01);
		take(6'h08, 16'h001B, 2'h3);
		quiet(6'h03);
		reti();
		quiet(6'h01);
		reti();
		take(6'h01, 16'h0003, 2'h0);
		reti();
		tend("nesting");
		wr(8'h87, 8'h01);
		rd(8'h87, 8'h01);
		wr(8'hA8, 8'hBD);
		quiet(6'h02);
		#1;
		chk({15'h0, idle_mode}, 16'h0001);
		wr(8'hA8, 8'hBF);
		take(6'h02, 16'h000B, 2'h1);
		#1;
		chk({15'h0, idle_mode}, 16'h0000);
		reti();
		tend("idle");
		finish_test();
	end
endmodule : tb_top
